// *** fpd_defs.svh ***
`ifndef FPD_DEFS_SVH
`define FPD_DEFS_SVH

// clock and base rates
`define FPD_CLK_HZ 50000000
`define FPD_FAST_HZ 360000
`define FPD_SLOW_HZ 1400
`define FPD_FAST_CYC ((`FPD_CLK_HZ) / (`FPD_FAST_HZ))
`define FPD_SLOW_CYC ((`FPD_CLK_HZ) / (`FPD_SLOW_HZ))

// register offsets
`define FPD_OFF_ECFG 8'h45
`define FPD_OFF_PCFG 8'h4A
`define FPD_OFF_DUTY 8'h4C
`define FPD_OFF_DIV 8'h4D
`define FPD_OFF_VID 8'hFE
`define FPD_OFF_REV 8'hFF

// field positions
`define FPD_HR_BIT 4
`define FPD_CKSL_BIT 3

// reset values
`define FPD_RST_DUTY 8'h00
`define FPD_RST_DIV 5'h08
`define FPD_RST_HR 1'b0
`define FPD_RST_CKSL 1'b0

// high-resolution full scale
`define FPD_HR_FULL 8'hFF

`endif

// *** fpd_pkg.sv ***
`default_nettype none

package fpd_pkg;
  typedef logic [7:0] fpd_byte_t;
  typedef enum logic {FPD_MODE_NORMAL, FPD_MODE_HIRES} fpd_mode_t;
endpackage : fpd_pkg

`default_nettype wire

// *** fpd_tick_div.sv ***
`default_nettype none

module fpd_tick_div (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // division length in clk cycles
  input wire logic [15:0] period,
  // one-cycle base clock enable
  output logic tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb begin
    tick = (cnt_r >= period - 16'h0001);
    cnt_nxt = tick ? 16'h0000 : cnt_r + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : fpd_tick_div

`default_nettype wire

// *** fpd_top.sv ***
// Behaviour
// RULE1: with the fast base clock the output period is 2N base ticks, so frequency is clock/2N.
// RULE2: with the slow base clock the same 2N division applies and high resolution is unavailable.
// RULE3: the 8-bit duty reading is used only while the high-resolution select bit is set.
// RULE4: the clock-select bit picks the base clock and high resolution needs it cleared.
// RULE5: high resolution with fast clock and N of eight gives a 22.5 kHz output with 8-bit duty.
// RULE6: in high resolution the duty cycle is the 8-bit duty value over 255.
// RULE7: in normal resolution the duty cycle is the duty value over 2N.
// RULE8: a frequency setting of zero behaves as a setting of one.
`include "fpd_defs.svh"
`default_nettype none

module fpd_top #(
  parameter int unsigned SLOW_CYC = `FPD_SLOW_CYC,
  parameter logic [7:0] VENDOR_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0] DIE_REV = 8'hA5     // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire fpd_pkg::fpd_byte_t reg_wdata,
  output fpd_pkg::fpd_byte_t reg_rdata,
  output logic reg_rvalid,
  // open-drain fan drive
  output logic pwm_out,
  output logic pwm_oe_n,
  output logic pwm_level,
  output fpd_pkg::fpd_mode_t pwm_mode
);
  import fpd_pkg::*;

  localparam logic [15:0] FAST_CYC = 16'(`FPD_FAST_CYC);
  localparam logic [15:0] SLOW_CYC_W = 16'(SLOW_CYC);

  // registers
  fpd_byte_t duty_r, duty_nxt;
  logic [4:0] div_r, div_nxt;
  logic hr_sel_r, hr_sel_nxt;
  logic cksl_r, cksl_nxt;
  fpd_byte_t rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  always_comb begin
    duty_nxt = duty_r;
    div_nxt = div_r;
    hr_sel_nxt = hr_sel_r;
    cksl_nxt = cksl_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_re;
    if (reg_we) begin
      case (reg_addr)
        `FPD_OFF_DUTY: duty_nxt = reg_wdata;
        `FPD_OFF_DIV: div_nxt = reg_wdata[4:0];
        `FPD_OFF_ECFG: hr_sel_nxt = reg_wdata[`FPD_HR_BIT];  // [RULE3]
        `FPD_OFF_PCFG: cksl_nxt = reg_wdata[`FPD_CKSL_BIT];  // [RULE4]
        default: ;
      endcase
    end
    if (reg_re) begin
      // unmapped offsets read zero; bits not held read zero
      case (reg_addr)
        `FPD_OFF_DUTY: rdata_nxt = duty_r;
        `FPD_OFF_DIV: rdata_nxt = {3'h0, div_r};
        `FPD_OFF_ECFG: rdata_nxt = 8'(hr_sel_r) << `FPD_HR_BIT;
        `FPD_OFF_PCFG: rdata_nxt = 8'(cksl_r) << `FPD_CKSL_BIT;
        `FPD_OFF_VID: rdata_nxt = VENDOR_ID;
        `FPD_OFF_REV: rdata_nxt = DIE_REV;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_r <= `FPD_RST_DUTY;
      div_r <= `FPD_RST_DIV;
      hr_sel_r <= `FPD_RST_HR;
      cksl_r <= `FPD_RST_CKSL;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      duty_r <= duty_nxt;
      div_r <= div_nxt;
      hr_sel_r <= hr_sel_nxt;
      cksl_r <= cksl_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // mode and divider
  logic [4:0] n_eff;
  logic [5:0] full;
  logic [13:0] hr_period;
  logic hires;
  logic tick;

  assign n_eff = (div_r == 5'h00) ? 5'h01 : div_r;  // [RULE8]
  assign full = {n_eff, 1'b0};
  // slow clock forbids the 8-bit duty reading
  assign hires = hr_sel_r & ~cksl_r;  // [RULE2] [RULE3] [RULE4]
  assign hr_period = 14'(full * FAST_CYC);
  assign pwm_mode = hires ? FPD_MODE_HIRES : FPD_MODE_NORMAL;

  fpd_tick_div u_tick (
    .clk(clk),
    .nrst(nrst),
    .period(cksl_r ? SLOW_CYC_W : FAST_CYC),  // [RULE1] [RULE2]
    .tick(tick)
  );

  // period counters
  logic [5:0] step_r, step_nxt;
  logic [13:0] hr_cnt_r, hr_cnt_nxt;
  logic level_r, level_nxt;
  logic [21:0] hr_lhs;
  logic [21:0] hr_rhs;

  always_comb begin
    step_nxt = step_r;
    hr_cnt_nxt = 14'h0000;
    hr_lhs = 22'(hr_cnt_r * 8'(`FPD_HR_FULL));
    hr_rhs = 22'(duty_r * hr_period);
    if (hires) begin
      // counts clk cycles so 255 duty steps fit in one period
      hr_cnt_nxt = (hr_cnt_r >= hr_period - 14'h0001) ? 14'h0000
                   : hr_cnt_r + 14'h0001;  // [RULE5]
      step_nxt = 6'h00;
      // full scale stays high even when a period change leaves the count past the end
      level_nxt = (hr_lhs < hr_rhs) || (duty_r == 8'(`FPD_HR_FULL));  // [RULE6]
    end else begin
      if (tick) begin
        step_nxt = (step_r >= full - 6'h01) ? 6'h00 : step_r + 6'h01;  // [RULE1]
      end
      // low six duty bits at or above 2N hold the output high, also while a shortened period
      // still carries a stale step count that only wraps at the next tick
      level_nxt = (step_r < duty_r[5:0]) || (duty_r[5:0] >= full);  // [RULE7]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      step_r <= 6'h00;
      hr_cnt_r <= 14'h0000;
      level_r <= 1'b0;
    end else begin
      step_r <= step_nxt;
      hr_cnt_r <= hr_cnt_nxt;
      level_r <= level_nxt;
    end
  end

  // open drain: drive low for the low part, release for the high part
  assign pwm_level = level_r;
  assign pwm_out = 1'b0;
  assign pwm_oe_n = level_r;

  chk_zero_div: assert property (@(posedge clk) disable iff (!nrst)  // [RULE8]
    div_r == 5'h00 |-> full == 6'h02)
    else $error("zero divider not treated as one");

  chk_slow_no_hr: assert property (@(posedge clk) disable iff (!nrst)  // [RULE2]
    cksl_r |-> pwm_mode == FPD_MODE_NORMAL)
    else $error("high resolution active on slow clock");

  chk_hr_needs_bit: assert property (@(posedge clk) disable iff (!nrst)  // [RULE3]
    pwm_mode == FPD_MODE_HIRES |-> hr_sel_r && !cksl_r)
    else $error("high resolution without select bit");

  chk_step_wrap: assert property (@(posedge clk) disable iff (!nrst)  // [RULE1]
    !hires && tick && step_r == full - 6'h01 ##1 !hires |-> step_r == 6'h00)
    else $error("normal period not 2N ticks");

  chk_norm_full: assert property (@(posedge clk) disable iff (!nrst)  // [RULE7]
    !hires && $stable(duty_r) && duty_r[5:0] >= full |=> level_r)
    else $error("full-scale duty not high");

  chk_norm_zero: assert property (@(posedge clk) disable iff (!nrst)  // [RULE7]
    !hires && duty_r[5:0] == 6'h00 |=> !level_r)
    else $error("zero duty not low");

  chk_hr_wrap: assert property (@(posedge clk) disable iff (!nrst)  // [RULE5]
    hires && $stable(hires) && hr_cnt_r == hr_period - 14'h0001 |=> hr_cnt_r == 14'h0000)
    else $error("high resolution period wrong");

  chk_hr_ends: assert property (@(posedge clk) disable iff (!nrst)  // [RULE6]
    hires && duty_r == `FPD_HR_FULL |=> level_r)
    else $error("hi-res full scale not 100 percent");

  chk_hr_bit_wr: assert property (@(posedge clk) disable iff (!nrst)  // [RULE3]
    reg_we && reg_addr == `FPD_OFF_ECFG |=> hr_sel_r == $past(reg_wdata[`FPD_HR_BIT]))
    else $error("select bit write lost");

  chk_tick_gap: assert property (@(posedge clk) disable iff (!nrst)  // [RULE1]
    tick && !cksl_r ##1 !cksl_r |-> !tick [*8])
    else $error("base ticks too close");

  chk_clk_sel_wr: assert property (@(posedge clk) disable iff (!nrst)  // [RULE4]
    reg_we && reg_addr == `FPD_OFF_PCFG |=> cksl_r == $past(reg_wdata[`FPD_CKSL_BIT]))
    else $error("clock select write lost");

  chk_div_wr: assert property (@(posedge clk) disable iff (!nrst)  // [RULE1]
    reg_we && reg_addr == `FPD_OFF_DIV |=> div_r == $past(reg_wdata[4:0]))
    else $error("frequency setting write lost");

  chk_hr_zero: assert property (@(posedge clk) disable iff (!nrst)  // [RULE6]
    hires && duty_r == 8'h00 |=> !level_r)
    else $error("hi-res zero duty not low");

  chk_norm_high: assert property (@(posedge clk) disable iff (!nrst)  // [RULE7]
    !hires && step_r < duty_r[5:0] |=> level_r)
    else $error("normal high time cut short");

  chk_hr_cnt_idle: assert property (@(posedge clk) disable iff (!nrst)  // [RULE3]
    !hires |=> hr_cnt_r == 14'h0000)
    else $error("hi-res counter running without select bit");
endmodule : fpd_top

`default_nettype wire

// *** fpd_fan_model.sv ***
`default_nettype none

module fpd_fan_model (
  // clock and fan speed-control pin
  input wire logic clk,
  input wire logic pin,
  // last full period and high time in clk cycles
  output logic [15:0] per_cnt,
  output logic [15:0] hi_cnt,
  output logic [7:0] n_per
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run = 16'h0000;
  logic [15:0] hi = 16'h0000;
  logic prev = 1'b0;
  initial n_per = 8'h00;
  // timed rise to rise, so a constant output lag cancels out
  always @(posedge clk) begin
    run <= run + 16'h0001;
    if (pin) begin
      hi <= hi + 16'h0001;
    end
    if (pin && !prev) begin
      per_cnt <= run;
      hi_cnt <= hi;
      run <= 16'h0001;
      hi <= 16'h0001;
      n_per <= n_per + 8'h01;
    end
    prev <= pin;
  end
endmodule : fpd_fan_model

`default_nettype wire

// *** tb.sv ***
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fpd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  fpd_byte_t reg_wdata = 8'h00;
  fpd_byte_t reg_rdata;
  logic reg_rvalid, pwm_out, pwm_oe_n, pwm_level;
  fpd_mode_t pwm_mode;
  logic [15:0] per_cnt, hi_cnt;
  logic [7:0] n_per;
  int bad_count = 0;
  int n_compared = 0;
  // pull-up on the fan pin while the drive is released
  wire logic fan_pin = pwm_oe_n ? 1'b1 : pwm_out;

  always #10 clk = ~clk;

  // short slow tick keeps the run brief; identity values arbitrary
  fpd_top #(.SLOW_CYC(20), .VENDOR_ID(8'h3C), .DIE_REV(8'hC3)) dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .pwm_level(pwm_level), .pwm_mode(pwm_mode));

  fpd_fan_model fan (.clk(clk), .pin(fan_pin), .per_cnt(per_cnt), .hi_cnt(hi_cnt),
    .n_per(n_per));

  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(posedge clk);
    #1;
    reg_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_re = 1'b1;
    @(posedge clk);
    #1;
    reg_re = 1'b0;
    check(reg_rvalid, 1);
    check(reg_rdata, exp);
  endtask : rd

  // three rises, so the last period is wholly under the new settings
  task automatic measure(input int per, input int hi);
    logic [7:0] s;
    int i;
    s = n_per;
    for (i = 0; i < 40000 && n_per != 8'(s + 8'h03); i++) begin
      @(posedge clk);
      #1;
    end
    if (i >= 40000) begin
      bad_count++;
      $display("unexpected at %0t: fan pin stopped toggling", $time);
      print_verdict();
    end
    check(per_cnt, per);
    check(hi_cnt, hi);
  endtask : measure

  task automatic t_regs();
    rd(8'hFE, 8'h3C);
    rd(8'hFF, 8'hC3);
    rd(8'h4C, 8'h00);
    rd(8'h4D, 8'h08);
    rd(8'h10, 8'h00);
    wr(8'hFE, 8'h00);
    rd(8'hFE, 8'h3C);
    wr(8'h4D, 8'hFF);
    rd(8'h4D, 8'h1F);
    wr(8'h45, 8'hFF);
    rd(8'h45, 8'h10);
    wr(8'h4A, 8'hFF);
    rd(8'h4A, 8'h08);
    wr(8'h45, 8'h00);
    wr(8'h4A, 8'h00);
  endtask : t_regs

  task automatic t_pwm();
    wr(8'h4D, 8'h02);
    wr(8'h4C, 8'h03);
    measure(552, 414);
    wr(8'h4D, 8'h00);
    wr(8'h4C, 8'h01);
    measure(276, 138);
    wr(8'h4A, 8'h08);
    wr(8'h4D, 8'h03);
    wr(8'h4C, 8'h02);
    measure(120, 40);
    wr(8'h45, 8'h10);
    check(pwm_mode, FPD_MODE_NORMAL);
    measure(120, 40);
    wr(8'h4A, 8'h00);
    wr(8'h4D, 8'h08);
    wr(8'h4C, 8'hBF);
    check(pwm_mode, FPD_MODE_HIRES);
    measure(2208, 1654);
    wr(8'h45, 8'h00);
    wr(8'h4C, 8'h0C);
    check(pwm_mode, FPD_MODE_NORMAL);
    measure(2208, 1656);
  endtask : t_pwm

  // counts the cycles in a window where the drive or the pin is off the level
  task automatic hold_level(input logic exp, input int n);
    int i;
    int off;
    off = 0;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (pwm_level !== exp || fan_pin !== exp) off++;
    end
    check(off, 0);
  endtask : hold_level

  // end points of both duty readings, where the pin never toggles
  task automatic t_levels();
    wr(8'h4C, 8'h00);
    hold_level(1'b0, 300);
    check(pwm_out, 0);
    wr(8'h4C, 8'h10);
    hold_level(1'b1, 300);
    wr(8'h45, 8'h10);
    wr(8'h4C, 8'hFF);
    hold_level(1'b1, 2300);
    wr(8'h4C, 8'h00);
    hold_level(1'b0, 2300);
  endtask : t_levels

  // reset in mid-run brings every setting back to its default
  task automatic t_reset();
    @(posedge clk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    check(pwm_mode, FPD_MODE_NORMAL);
    rd(8'h45, 8'h00);
    rd(8'h4A, 8'h00);
    rd(8'h4C, 8'h00);
    rd(8'h4D, 8'h08);
    hold_level(1'b0, 20);
  endtask : t_reset

  initial begin
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_regs();
    t_pwm();
    t_levels();
    t_reset();
    print_verdict();
  end
endmodule : tb

`default_nettype wire
